/* core/otg_irq_pkg.sv */
// Package for the transceiver status and interrupt latch block.
// Holds register offsets, reset values, field layouts and carrier structs.
// Assumes a register port that already decodes a serial bus into byte accesses.
`default_nettype none

package otg_irq_pkg;

    // Register offsets on the byte-wide register port
    localparam logic [7:0] ADDR_SOURCE = 8'h08;
    localparam logic [7:0] ADDR_LATCH_SET = 8'h0A;
    localparam logic [7:0] ADDR_LATCH_CLR = 8'h0B;
    localparam logic [7:0] ADDR_FALL_SET = 8'h0C;
    localparam logic [7:0] ADDR_FALL_CLR = 8'h0D;
    localparam logic [7:0] ADDR_RISE_SET = 8'h0E;
    localparam logic [7:0] ADDR_RISE_CLR = 8'h0F;

    // Values after reset
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] FALL_EN_RESET = 8'h00;
    localparam logic [7:0] RISE_EN_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Falling-edge enable bit 6 is reserved and always reads zero
    localparam logic [7:0] FALL_EN_WRITABLE = 8'hBF;

    // Field positions inside the source byte
    localparam int SRC_SUPPLY_VALID = 0;
    localparam int SRC_SESSION_VALID = 1;
    localparam int SRC_PLUS_LEVEL = 2;
    localparam int SRC_ID_GROUNDED = 3;
    localparam int SRC_MINUS_LEVEL = 4;

    // Number of detector inputs passing the synchroniser
    localparam int DET_WIDTH = 11;

    // Cycles after reset before edges are believed (sync depth plus history)
    localparam logic [2:0] WARMUP_CYCLES = 3'h4;

    // Source byte, bit 7 down to bit 0
    typedef struct packed {
        logic carkit_event;
        logic disconnect_then_pullup;
        logic id_pin_open;
        logic minus_line_level;
        logic id_pin_grounded;
        logic plus_line_level;
        logic session_valid_flag;
        logic supply_valid_flag;
    } source_bits_t;

    // Raw detector and mode levels from the analog front end
    typedef struct packed {
        logic power_down;
        logic carkit_event;
        logic disconnect_then_pullup;
        logic id_pin_open;
        logic minus_line_level;
        logic id_pin_grounded;
        logic plus_line_level;
        logic vbus_above_a_session;
        logic vbus_above_b_session;
        logic vbus_above_valid;
        logic b_session_ended;
    } detector_in_t;

    // Register access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage : otg_irq_pkg

`default_nettype wire

/* core/source_sync.sv */
// Two-flop synchroniser bank for the detector levels.
// Assumes each input is a slow level; bits are synchronised independently.
`default_nettype none

module source_sync (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [otg_irq_pkg::DET_WIDTH-1:0] raw,
    output logic [otg_irq_pkg::DET_WIDTH-1:0] synced
);

    ////////////////////////////////////////////////////////////////////////////
    // Per-bit chain; the first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < otg_irq_pkg::DET_WIDTH; i++) begin : g_bit
            logic stage1; // Metastability catcher, read by stage two only
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    stage1 <= 1'b0;
                    synced[i] <= 1'b0;
                end else begin
                    stage1 <= raw[i];
                    synced[i] <= stage1;
                end
            end
        end
    endgenerate

endmodule : source_sync

`default_nettype wire

/* core/otg_status_interrupt_latch.sv */
// Status source, interrupt latch and edge enables of a USB OTG transceiver.
// Assumes a byte register port already decoded from the serial bus, one
// access per pulse, and detector levels from the analog front end.
`default_nettype none

// Behaviour
// - Bit 4 mirrors minus-line receiver level
// - Bit 3 reads one when ID grounded
// - Power-down forces ID-grounded bit to zero
// - Bit 2 mirrors plus-line receiver level
// - Bit 1 session valid, threshold chosen by ID
// - ID grounded: bit 0 is supply valid
// - ID open: bit 0 is session-end detector
// - Session end reads one below threshold
// - Latch bit sits at its source position
// - Latch at 0Ah set, 0Bh clear, resets zero
// - Latch bits cover sources seven down to zero
// - Fall enable lets falling edge set latch
// - Fall enable at 0Ch/0Dh, bit 6 reserved
// - Writing one at set address sets bit
// - Rise enable lets rising edge set latch
// - Interrupt pin low while any latch bit set
module otg_status_interrupt_latch (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire otg_irq_pkg::detector_in_t det_in,  // Raw detector levels
    input wire otg_irq_pkg::reg_req_t reg_req,     // Register access request
    output logic [7:0] reg_rdata,                  // Read data, one cycle after rd
    output logic reg_rvalid,                       // Read data valid pulse
    output logic irq_n                             // Active-low interrupt pin
);

    ////////////////////////////////////////////////////////////////////////////
    // Synchronised detector levels
    otg_irq_pkg::detector_in_t det_sync; // Detector levels in the clock domain
    logic [otg_irq_pkg::DET_WIDTH-1:0] det_sync_vec; // Flat view for the bank

    source_sync u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .raw(det_in),
        .synced(det_sync_vec)
    );

    assign det_sync = det_sync_vec;

    ////////////////////////////////////////////////////////////////////////////
    // Live source composition
    otg_irq_pkg::source_bits_t next_source; // Source byte before registering
    otg_irq_pkg::source_bits_t live_status; // Registered source byte
    otg_irq_pkg::source_bits_t prev_status; // Source byte one cycle older
    logic id_pin_grounded_eff;                       // ID grounded after power-down gating

    // Combine detectors; the ID role picks the thresholds
    always_comb begin
        id_pin_grounded_eff = det_sync.id_pin_grounded && !det_sync.power_down;
        next_source.minus_line_level = det_sync.minus_line_level;
        next_source.id_pin_grounded = id_pin_grounded_eff;
        next_source.plus_line_level = det_sync.plus_line_level;
        // Session valid against A or B threshold by role
        next_source.session_valid_flag = id_pin_grounded_eff ? det_sync.vbus_above_a_session
                                                    : det_sync.vbus_above_b_session;
        // Bit 0 doubles as supply valid or session end
        if (id_pin_grounded_eff) begin
            next_source.supply_valid_flag = det_sync.vbus_above_valid;
        end else begin
            next_source.supply_valid_flag = det_sync.b_session_ended;
        end
        // Carkit event is also held low in power-down
        next_source.carkit_event = det_sync.carkit_event && !det_sync.power_down;
        next_source.disconnect_then_pullup = det_sync.disconnect_then_pullup;
        next_source.id_pin_open = det_sync.id_pin_open;
    end

    // Register the source byte and keep one cycle of history
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            live_status <= '0;
            prev_status <= '0;
        end else begin
            live_status <= next_source;
            prev_status <= live_status;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Warm-up: no edges until the sync chain and history hold real levels
    logic [2:0] warm_count; // Cycles since reset release, saturating
    logic primed;           // History valid, edges may be trusted

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            warm_count <= 3'h0;
        end else if (warm_count != otg_irq_pkg::WARMUP_CYCLES) begin
            warm_count <= warm_count + 3'h1;
        end
    end

    // Avoids a spurious edge from the reset zeros of the pipeline
    assign primed = (warm_count == otg_irq_pkg::WARMUP_CYCLES);

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection and register write decode
    logic [7:0] rise_edges;  // Sources that went 0 to 1 this cycle
    logic [7:0] fall_edges;  // Sources that went 1 to 0 this cycle
    logic [7:0] hw_set;      // Qualified edges that set latch bits
    logic [7:0] latch;       // Interrupt latch
    logic [7:0] fall_en;     // Falling-edge enables
    logic [7:0] rise_en;     // Rising-edge enables
    logic [7:0] next_latch;  // Latch value for the next edge
    logic [7:0] sw_set_mask; // Latch bits written one at set address
    logic [7:0] sw_clr_mask; // Latch bits written one at clear address

    assign rise_edges = primed ? (live_status & ~prev_status) : 8'h00;
    assign fall_edges = primed ? (~live_status & prev_status) : 8'h00;
    assign hw_set = (rise_edges & rise_en) | (fall_edges & fall_en);
    assign sw_set_mask = (reg_req.wr && reg_req.addr == otg_irq_pkg::ADDR_LATCH_SET)
                         ? reg_req.wdata : 8'h00;
    assign sw_clr_mask = (reg_req.wr && reg_req.addr == otg_irq_pkg::ADDR_LATCH_CLR)
                         ? reg_req.wdata : 8'h00;

    // Set wins over clear so an edge landing on a clear is kept
    assign next_latch = (latch & ~sw_clr_mask) | sw_set_mask | hw_set;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt latch and pin
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            latch <= otg_irq_pkg::LATCH_RESET;
            irq_n <= 1'b1;
        end else begin
            latch <= next_latch;
            irq_n <= (next_latch == 8'h00);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Falling-edge enables; reserved bit 6 never stores
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fall_en <= otg_irq_pkg::FALL_EN_RESET;
        end else if (reg_req.wr && reg_req.addr == otg_irq_pkg::ADDR_FALL_SET) begin
            fall_en <= fall_en | (reg_req.wdata & otg_irq_pkg::FALL_EN_WRITABLE);
        end else if (reg_req.wr && reg_req.addr == otg_irq_pkg::ADDR_FALL_CLR) begin
            fall_en <= fall_en & ~reg_req.wdata;
        end
    end

    // Rising-edge enables
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rise_en <= otg_irq_pkg::RISE_EN_RESET;
        end else if (reg_req.wr && reg_req.addr == otg_irq_pkg::ADDR_RISE_SET) begin
            rise_en <= rise_en | reg_req.wdata;
        end else if (reg_req.wr && reg_req.addr == otg_irq_pkg::ADDR_RISE_CLR) begin
            rise_en <= rise_en & ~reg_req.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port: set and clear addresses both return the stored value
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= otg_irq_pkg::READ_UNMAPPED;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_req.rd;
            if (reg_req.rd) begin
                case (reg_req.addr)
                    otg_irq_pkg::ADDR_SOURCE: reg_rdata <= live_status;
                    otg_irq_pkg::ADDR_LATCH_SET,
                    otg_irq_pkg::ADDR_LATCH_CLR: reg_rdata <= latch;
                    otg_irq_pkg::ADDR_FALL_SET,
                    otg_irq_pkg::ADDR_FALL_CLR: reg_rdata <= fall_en;
                    otg_irq_pkg::ADDR_RISE_SET,
                    otg_irq_pkg::ADDR_RISE_CLR: reg_rdata <= rise_en;
                    default: reg_rdata <= otg_irq_pkg::READ_UNMAPPED; // Unmapped reads zero
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_minus_mirror: assert property (
        ##1 live_status.minus_line_level == $past(det_sync.minus_line_level))
        else $error("minus line bit does not follow receiver");
    a_id_grounded: assert property (
        ##1 !$past(det_sync.power_down) |->
            live_status.id_pin_grounded == $past(det_sync.id_pin_grounded))
        else $error("id grounded bit wrong");
    a_id_powerdown: assert property (
        $past(det_sync.power_down) |-> !live_status.id_pin_grounded)
        else $error("id grounded bit not forced low in power-down");
    a_plus_mirror: assert property (
        ##1 live_status.plus_line_level == $past(det_sync.plus_line_level))
        else $error("plus line bit does not follow receiver");
    a_session_select: assert property (
        ##1 live_status.session_valid_flag == ($past(id_pin_grounded_eff)
            ? $past(det_sync.vbus_above_a_session) : $past(det_sync.vbus_above_b_session)))
        else $error("session valid threshold chosen wrongly");
    a_bit0_select: assert property (
        ##1 live_status.supply_valid_flag == ($past(id_pin_grounded_eff)
            ? $past(det_sync.vbus_above_valid) : $past(det_sync.b_session_ended)))
        else $error("bit 0 function chosen wrongly");
    a_fall_latches: assert property (
        primed |=> ((latch & $past(~live_status & prev_status & fall_en))
            == $past(~live_status & prev_status & fall_en)))
        else $error("enabled falling edge not latched");
    a_rise_latches: assert property (
        primed |=> ((latch & $past(live_status & ~prev_status & rise_en))
            == $past(live_status & ~prev_status & rise_en)))
        else $error("enabled rising edge not latched");
    a_no_edge_no_set: assert property (
        (hw_set == 8'h00 && sw_set_mask == 8'h00) |=> ((latch & ~$past(latch)) == 8'h00))
        else $error("latch bit set without cause");
    a_fall_reserved: assert property (
        fall_en[6] == 1'b0)
        else $error("reserved falling enable bit stored");
    a_sw_set: assert property (
        (sw_set_mask != 8'h00) |=> ((latch & $past(sw_set_mask)) == $past(sw_set_mask)))
        else $error("set address write did not set bits");
    a_sw_clear: assert property (
        (sw_clr_mask != 8'h00 && hw_set == 8'h00) |=> ((latch & $past(sw_clr_mask)) == 8'h00))
        else $error("clear address write did not clear bits");
    a_irq_pin: assert property (
        irq_n == (latch == 8'h00))
        else $error("interrupt pin disagrees with latch");

endmodule : otg_status_interrupt_latch

`default_nettype wire

/* testbench/reg_host_model.sv */
// Host side model: drives the byte register port as the serial engine would.
// Assumes the port takes one access per clock edge, with wr and rd as pulses.
`default_nettype none

module reg_host_model (
    input wire logic clk_sys,
    output var otg_irq_pkg::reg_req_t reg_req
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////
    // Idle until the bench asks for an access
    initial begin
        reg_req = '0;
    end

    // One access held for exactly one taking edge, then released to idle
    // Set and clear semantics are the host's choice of address and ones
    task automatic access(input logic wr, input logic rd, input logic [7:0] addr,
                          input logic [7:0] wdata);
        @(posedge clk_sys);
        reg_req <= '{wr: wr, rd: rd, addr: addr, wdata: wdata};
        @(posedge clk_sys);
        reg_req <= '0;
    endtask : access
endmodule : reg_host_model

`default_nettype wire

/* testbench/otg_status_interrupt_latch_bench.sv */
// Self-checking bench for the status source and interrupt latch block.
// Assumes the host model above and detector levels driven here.
`default_nettype none

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module otg_status_interrupt_latch_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys;
    logic rst_n;
    otg_irq_pkg::detector_in_t det; // Detector levels
    otg_irq_pkg::reg_req_t reg_req;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic irq_n;
    logic [7:0] exp_q[$]; // Expected read data, oldest first
    logic [7:0] exp_v;
    logic [31:0] seed;
    logic [31:0] r;
    logic [7:0] w;
    int error_cnt;
    int n_tests;

    reg_host_model host_u (.clk_sys(clk_sys), .reg_req(reg_req));

    otg_status_interrupt_latch dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .det_in(det),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .irq_n(irq_n));

    ////////////////////////////////////////////////////////////////////////
    // 200 MHz clock
    always #2.5 clk_sys = ~clk_sys;

    // Pseudo-random source, fixed start
    function automatic logic [31:0] next_rand(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        next_rand = x ^ (x << 5);
    endfunction : next_rand

    // Expected source byte; the mode choice uses the forced ID bit
    function automatic logic [7:0] src_model(input otg_irq_pkg::detector_in_t d);
        logic gnd;
        gnd = d.id_pin_grounded & ~d.power_down;
        src_model = {d.carkit_event & ~d.power_down, d.disconnect_then_pullup,
            d.id_pin_open, d.minus_line_level, gnd, d.plus_line_level,
            gnd ? d.vbus_above_a_session : d.vbus_above_b_session,
            gnd ? d.vbus_above_valid : d.b_session_ended};
    endfunction : src_model

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_u.access(1'b1, 1'b0, a, d);
    endtask : wr

    // Note the expectation first, so the watcher finds it when data returns
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_u.access(1'b0, 1'b1, a, 8'h00);
    endtask : rd

    // Change the detector levels just after an edge, then let sync settle
    task automatic set_det(input logic [10:0] v);
        @(posedge clk_sys);
        det <= v;
        tick(8);
    endtask : set_det

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////
    // Read watcher: every valid pulse takes the oldest note
    always @(posedge clk_sys) begin
        if (reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                error_cnt++;
                $display("MISMATCH reg_rvalid expected 0 seen 1");
            end else begin
                exp_v = exp_q.pop_front();
                `CHK("reg_rdata", exp_v, reg_rdata)
            end
        end
    end

    // Hang guard; the run needs well under this
    initial begin
        tick(20000);
        error_cnt++;
        $display("MISMATCH watchdog expected finish seen hang");
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        det = '0;
        seed = 32'h0000D8B2;
        error_cnt = 0;
        n_tests = 0;
        tick(8);
        rst_n <= 1'b1;
        tick(8);
        // Reset values; warm-up is over before anything moves
        rd(otg_irq_pkg::ADDR_LATCH_SET, otg_irq_pkg::LATCH_RESET);
        rd(otg_irq_pkg::ADDR_FALL_SET, otg_irq_pkg::FALL_EN_RESET);
        rd(otg_irq_pkg::ADDR_RISE_SET, otg_irq_pkg::RISE_EN_RESET);
        `CHK("irq_n", 1'b1, irq_n)
        $display("test reset done");
        // Random detector levels, power-down included; enables all off
        for (int i = 0; i < 16; i++) begin
            seed = next_rand(seed);
            set_det(seed[10:0]);
            rd(otg_irq_pkg::ADDR_SOURCE, src_model(det));
        end
        rd(otg_irq_pkg::ADDR_LATCH_SET, 8'h00);
        $display("test source map done");
        // Software set and clear of the latch with random data, then of the falling enables
        set_det(11'h040);
        seed = next_rand(seed);
        w = seed[7:0] | 8'h81;
        wr(otg_irq_pkg::ADDR_LATCH_SET, w);
        rd(otg_irq_pkg::ADDR_LATCH_SET, w);
        `CHK("irq_n", 1'b0, irq_n)
        wr(otg_irq_pkg::ADDR_LATCH_SET, 8'h00);
        wr(otg_irq_pkg::ADDR_LATCH_CLR, 8'h0F);
        rd(otg_irq_pkg::ADDR_LATCH_CLR, w & 8'hF0);
        `CHK("irq_n", 1'b0, irq_n)
        wr(otg_irq_pkg::ADDR_LATCH_CLR, 8'hFF);
        rd(otg_irq_pkg::ADDR_LATCH_SET, 8'h00);
        `CHK("irq_n", 1'b1, irq_n)
        wr(otg_irq_pkg::ADDR_FALL_SET, 8'hFF);
        rd(otg_irq_pkg::ADDR_FALL_SET, otg_irq_pkg::FALL_EN_WRITABLE);
        wr(otg_irq_pkg::ADDR_FALL_CLR, 8'h0F);
        rd(otg_irq_pkg::ADDR_FALL_CLR, 8'hB0);
        $display("test set clear done");
        // Falling minus level with its enable on latches bit 4 once
        set_det(11'h000);
        rd(otg_irq_pkg::ADDR_LATCH_SET, 8'h10);
        `CHK("irq_n", 1'b0, irq_n)
        wr(otg_irq_pkg::ADDR_LATCH_CLR, 8'hFF);
        tick(8);
        rd(otg_irq_pkg::ADDR_LATCH_SET, 8'h00);
        // Rising plus level with only its rise enable on
        wr(otg_irq_pkg::ADDR_RISE_SET, 8'h04);
        set_det(11'h010);
        rd(otg_irq_pkg::ADDR_LATCH_SET, 8'h04);
        wr(otg_irq_pkg::ADDR_LATCH_CLR, 8'hFF);
        // Rise enable clear, ignored write to the source, unmapped read
        wr(otg_irq_pkg::ADDR_RISE_CLR, 8'h04);
        rd(otg_irq_pkg::ADDR_RISE_CLR, otg_irq_pkg::RISE_EN_RESET);
        wr(otg_irq_pkg::ADDR_SOURCE, 8'hFF);
        rd(otg_irq_pkg::ADDR_SOURCE, src_model(det));
        rd(8'h10, otg_irq_pkg::READ_UNMAPPED);
        // Reserved fall enable: disconnect falling must not latch bit 6,
        // while the plus level falling on the way relatches bit 2
        wr(otg_irq_pkg::ADDR_FALL_SET, 8'hFF);
        set_det(11'h100);
        set_det(11'h000);
        rd(otg_irq_pkg::ADDR_LATCH_SET, 8'h04);
        $display("test edges done");
        for (int i = 0; i < 10 && exp_q.size() > 0; i++) begin
            tick(1);
        end
        if (exp_q.size() > 0) begin
            error_cnt++;
            $display("MISMATCH read_queue expected 0 seen %0d", exp_q.size());
        end
        test_done();
    end
endmodule : otg_status_interrupt_latch_bench

`default_nettype wire
